// >>> verilog/watchdog_pkg.sv
// Constants, register map and types of the watchdog mode guard.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package watchdog_pkg;
  ////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADR_MODE   = 8'h00;
  localparam logic [7:0] ADR_KEY    = 8'h04;
  localparam logic [7:0] ADR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADR_IRQ_CL = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  ////////////////////////////////////////////////////////////////////
  // Codes and fields
  localparam logic [7:0] KEY_CODE = 8'hAC;
  localparam logic [7:0] KEY_READ = 8'h9A;
  localparam logic [7:0] MODE_RST = 8'h67;
  localparam logic [2:0] TOP_PAT  = 3'h3;
  localparam int         TOP_LSB  = 5;
  localparam int         STOP_POS = 4;
  localparam int         SEL_MSB  = 2;
  localparam int         CNT_W    = 16;
  localparam int         CNT_BASE = 8;
  ////////////////////////////////////////////////////////////////////
  // Interrupt events
  localparam int EV_ILL = 0;
  localparam int EV_KEY = 1;
  localparam int EV_OVF = 2;
  localparam int EV_WR  = 3;
  localparam int EV_W   = 4;
  ////////////////////////////////////////////////////////////////////
  // Timing: watchdog source tick period
  localparam int CLK_MHZ  = 20;
  localparam int TICK_NS  = 200;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
  localparam int BOOT_CYC = 3;
  ////////////////////////////////////////////////////////////////////
  // Bus slave states, Gray along idle, wait, answer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ANS  = 2'b11
  } apb_state_type;
endpackage
`default_nettype wire

// >>> verilog/watchdog_mode_guard.sv
// Watchdog timer with a write-once guarded mode register on APB.
// Assumes one 20 MHz clock; halt and stop levels come from the CPU
// on this clock, source-run and option strap come from pins.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module watchdog_mode_guard (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic        halt_i,
  input  wire logic        stop_i,
  input  wire logic        src_run_i,
  input  wire logic        opt_nonstop_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  output logic             irq_o,
  output logic             wdt_reset_o
);
  ////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] limit(input logic [2:0] sel);
    limit = 16'h0001 << (int'(sel) + watchdog_pkg::CNT_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  watchdog_pkg::apb_state_type st_r, st_nxt;
  logic                     pready_r;
  logic [31:0]              prdata_r;
  logic                     pslverr_r;
  logic [7:0]               mode_r;
  logic                     written_r;
  logic                     stopped_r;
  logic                     pend_r;
  logic                     rst_out_r;
  logic [15:0]              cnt_r;
  logic [7:0]               div_r;
  logic                     tick_r;
  logic                     s1_r, s2_r, s3_r, run_q_r;
  logic                     o1_r, o2_r, o3_r, opt_r;
  logic [1:0]               boot_r;
  logic [3:0]               ist_r, ien_r;
  logic                     irq_r;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  wire acc      = psel_i & penable_i;
  wire done     = acc & pready_r;
  wire wr_done  = done & pwrite_i;
  wire a_mode   = hit(paddr_i, watchdog_pkg::ADR_MODE);
  wire a_key    = hit(paddr_i, watchdog_pkg::ADR_KEY);
  wire a_ist    = hit(paddr_i, watchdog_pkg::ADR_IRQ_ST);
  wire a_ien    = hit(paddr_i, watchdog_pkg::ADR_IRQ_EN);
  wire a_icl    = hit(paddr_i, watchdog_pkg::ADR_IRQ_CL);
  wire a_stat   = hit(paddr_i, watchdog_pkg::ADR_STATUS);
  wire mapped   = a_mode | a_key | a_ist | a_ien | a_icl | a_stat;
  wire byte_ok  = pstrb_i[0];
  wire mode_acc = pwrite_i & a_mode;
  wire mode_wr  = wr_done & a_mode & byte_ok;
  wire key_wr   = wr_done & a_key;
  wire bad_key  = key_wr & (~byte_ok |
                  (pwdata_i[7:0] != watchdog_pkg::KEY_CODE));
  // A stopped watchdog swallows later mode writes silently
  wire ill_wr   = mode_wr & written_r & ~stopped_r;
  wire first_wr = mode_wr & ~written_r;
  wire good_key = key_wr & ~bad_key;
  wire bad_acc  = ~mapped | (pwrite_i & a_ist) |
                  (mode_acc & ~byte_ok);

  wire [31:0] stat_word = {cnt_r, 12'h000, opt_r, pend_r,
                           stopped_r, written_r};
  wire [31:0] rdata =
      a_mode ? {24'h00_0000, mode_r} :
      a_key  ? {24'h00_0000, watchdog_pkg::KEY_READ} :
      a_ist  ? {28'h000_0000, ist_r} :
      a_ien  ? {28'h000_0000, ien_r} :
      a_stat ? stat_word : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Bus slave sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      watchdog_pkg::ST_IDLE: begin
        if (acc && mode_acc) begin
          st_nxt = watchdog_pkg::ST_WAIT;
        end else if (acc) begin
          st_nxt = watchdog_pkg::ST_ANS;
        end
      end
      watchdog_pkg::ST_WAIT: st_nxt = watchdog_pkg::ST_ANS;
      watchdog_pkg::ST_ANS:  st_nxt = watchdog_pkg::ST_IDLE;
      default:               st_nxt = watchdog_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r      <= watchdog_pkg::ST_IDLE;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      pready_r <= (st_nxt == watchdog_pkg::ST_ANS);
      if (st_nxt == watchdog_pkg::ST_ANS) begin
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rdata;
        pslverr_r <= bad_acc;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and option strap capture
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      {s1_r, s2_r, s3_r, run_q_r} <= 4'h0;
    end else begin
      s1_r <= src_run_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        run_q_r <= s3_r;
      end
    end
  end

  // Strap flops run through reset, so the strap has settled by release;
  // clearing them would make a high strap look unsettled in the window
  always_ff @(posedge clk_sys_i) begin
    o1_r <= opt_nonstop_i;
    o2_r <= o1_r;
    o3_r <= o2_r;
  end

  // Until the strap settles the safer non-stoppable option holds
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      boot_r <= 2'h0;
      opt_r  <= 1'b1;
    end else if (boot_r != 2'(watchdog_pkg::BOOT_CYC)) begin
      boot_r <= boot_r + 2'h1;
      if (o2_r == o3_r) begin
        opt_r <= o3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Source tick divider
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_r == 8'(watchdog_pkg::TICK_CYC - 1)) begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode register, write once
  wire [7:0] mode_in = opt_r ?
      {watchdog_pkg::TOP_PAT, 1'b0, pwdata_i[3:0]} :
      pwdata_i[7:0];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mode_r    <= watchdog_pkg::MODE_RST;
      written_r <= 1'b0;
      stopped_r <= 1'b0;
    end else if (first_wr) begin
      mode_r    <= mode_in;
      written_r <= 1'b1;
      stopped_r <= mode_in[watchdog_pkg::STOP_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter
  wire hold  = ~opt_r & (halt_i | stop_i);
  wire run   = tick_r & run_q_r & ~stopped_r & ~hold;
  wire [15:0] lim = limit(mode_r[watchdog_pkg::SEL_MSB:0]);
  wire ovf   = run & (cnt_r == lim - 16'h0001);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_r <= 16'h0000;
    end else if (good_key || ovf) begin
      cnt_r <= 16'h0000;
    end else if (run) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Internal reset request
  // The request waits for a running source clock, then stays high
  // until the system reset takes down all but the strap flops.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pend_r    <= 1'b0;
      rst_out_r <= 1'b0;
    end else begin
      if (ill_wr || bad_key || ovf) begin
        pend_r <= 1'b1;
      end
      if (pend_r && run_q_r) begin
        rst_out_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear
  logic [3:0] ev;
  always_comb begin
    ev = 4'h0;
    ev[watchdog_pkg::EV_ILL] = ill_wr;
    ev[watchdog_pkg::EV_KEY] = bad_key;
    ev[watchdog_pkg::EV_OVF] = ovf;
    ev[watchdog_pkg::EV_WR]  = first_wr;
  end
  wire [3:0] clr = (wr_done & a_icl) ? pwdata_i[3:0] : 4'h0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ist_r <= 4'h0;
      ien_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~clr) | ev;
      irq_r <= |(((ist_r & ~clr) | ev) & ien_r);
      if (wr_done && a_ien) begin
        ien_r <= pwdata_i[3:0];
      end
    end
  end

  assign pready_o    = pready_r;
  assign prdata_o    = prdata_r;
  assign pslverr_o   = pslverr_r;
  assign irq_o       = irq_r;
  assign wdt_reset_o = rst_out_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  AST_MODE_WAIT: assert property (
    st_r == watchdog_pkg::ST_IDLE && acc && mode_acc
    |-> !pready_o ##1 !pready_o ##1 pready_o)
    else $error("mode write not stretched by one wait");

  AST_ONCE: assert property (
    first_wr |=> written_r &&
      mode_r[3:0] == $past(pwdata_i[3:0]))
    else $error("first mode write not stored");

  AST_BYTE_ONLY: assert property (
    wr_done && a_mode && !byte_ok |=> $stable(mode_r))
    else $error("partial mode write changed the register");

  AST_IGNORE_TOP: assert property (
    opt_r && first_wr |=>
      mode_r[7:watchdog_pkg::TOP_LSB] == watchdog_pkg::TOP_PAT
      && !stopped_r)
    else $error("upper mode bits taken in non-stoppable option");

  AST_SECOND_WR: assert property (
    mode_wr && written_r && !stopped_r |=> pend_r)
    else $error("second mode write raised no reset");

  AST_DEFER: assert property (
    pend_r && !run_q_r && !wdt_reset_o |=> !wdt_reset_o)
    else $error("reset fired while source clock stopped");

  AST_FIRE: assert property (
    pend_r && run_q_r |=> wdt_reset_o)
    else $error("pending reset not fired on running source");

  AST_NO_RESTART: assert property (
    stopped_r && !good_key |=> stopped_r && $stable(cnt_r))
    else $error("stopped watchdog counted again");

  AST_NO_RST: assert property (
    stopped_r && mode_wr && !pend_r |=> !pend_r)
    else $error("mode write on stopped watchdog raised reset");

  AST_BAD_KEY: assert property (
    key_wr && pwdata_i[7:0] != watchdog_pkg::KEY_CODE |=> pend_r)
    else $error("wrong key raised no reset");

  AST_KEY_READ: assert property (
    st_r == watchdog_pkg::ST_IDLE && acc && !pwrite_i && a_key
    |=> prdata_o[7:0] == watchdog_pkg::KEY_READ)
    else $error("key register read wrong constant");

  AST_NONSTOP: assert property (
    opt_r && stop_i && tick_r && run_q_r && !stopped_r
    && !good_key && !ovf |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("non-stoppable watchdog paused in stop");

  AST_HOLD: assert property (
    !opt_r && (halt_i || stop_i) && !good_key |=> $stable(cnt_r))
    else $error("count moved in halt or stop");

  AST_OVF: assert property (
    ovf ##1 run_q_r |=> wdt_reset_o)
    else $error("overflow raised no reset");

  COV_FIRST: cover property (first_wr ##[1:20] good_key);
  COV_SECOND: cover property (ill_wr ##[1:10] wdt_reset_o);
  COV_DEFER: cover property (pend_r && !run_q_r ##1 run_q_r);
  COV_STOP: cover property (stopped_r && mode_wr);
endmodule
`default_nettype wire

// >>> bench/watchdog_mode_guard_tb.sv
// Self-checking bench for the watchdog mode guard, driven over APB.
// Assumes the design package is compiled first; one 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); end end
module watchdog_mode_guard_tb;
  logic        clk_sys_i;
  logic        rst_b_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic        halt_i;
  logic        stop_i;
  logic        src_run_i;
  logic        opt_nonstop_i;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        irq_o;
  logic        wdt_reset_o;
  logic [31:0] rd;
  logic        er;
  logic [15:0] c_a;
  logic [15:0] c_b;
  int          nw;
  int          num_errors;
  int          n_checks;

  watchdog_mode_guard DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .halt_i(halt_i), .stop_i(stop_i), .src_run_i(src_run_i),
    .opt_nonstop_i(opt_nonstop_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));

  always #25 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Signals move just after a rising edge and hold until pready is seen at one
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys_i);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d; pstrb_i <= s;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    nw = 0;
    do begin
      @(posedge clk_sys_i);
      nw++;
    end while (pready_o !== 1'b1 && nw < 20);
    if (nw >= 20) begin
      num_errors++;
      $display("BAD %0t no answer", $time);
      final_report();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask

  task automatic wait_rst(input int lim);
    int i;
    i = 0;
    while (wdt_reset_o !== 1'b1 && i < lim) begin
      @(posedge clk_sys_i);
      i++;
    end
    n_checks++;
    if (i >= lim) begin
      num_errors++;
      $display("BAD %0t internal reset missing", $time);
      final_report();
    end
  endtask

  task automatic do_reset(input logic opt);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0; opt_nonstop_i <= opt; halt_i <= 1'b0; stop_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic rd_cnt(output logic [15:0] c);
    apb(1'b0, watchdog_pkg::ADR_STATUS, 32'h0000_0000, 4'h0);
    c = rd[31:16];
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0; rst_b_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 8'h00; pwdata_i = 32'h0000_0000; pstrb_i = 4'h0; halt_i = 1'b0;
    stop_i = 1'b0; src_run_i = 1'b1; opt_nonstop_i = 1'b0; num_errors = 0; n_checks = 0;
    do_reset(1'b0);
    apb(1'b0, watchdog_pkg::ADR_MODE, 32'h0000_0000, 4'h0);
    `CHK(rd[7:0], watchdog_pkg::MODE_RST)
    apb(1'b0, watchdog_pkg::ADR_KEY, 32'h0000_0000, 4'h0);
    `CHK(rd[7:0], watchdog_pkg::KEY_READ)
    `CHK(nw, 2)
    apb(1'b1, 8'h20, 32'h0000_0001, 4'h1);
    `CHK(er, 1'b1)
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0060, 4'h2);
    `CHK(er, 1'b1)
    // Interrupt masked first, then enabled, then cleared
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0061, 4'h1);
    `CHK(nw, 3)
    apb(1'b0, watchdog_pkg::ADR_MODE, 32'h0000_0000, 4'h0);
    `CHK(rd[7:0], 8'h61)
    apb(1'b0, watchdog_pkg::ADR_IRQ_ST, 32'h0000_0000, 4'h0);
    `CHK(rd[3:0], 4'h8)
    @(negedge clk_sys_i);
    `CHK(irq_o, 1'b0)
    apb(1'b1, watchdog_pkg::ADR_IRQ_EN, 32'h0000_0009, 4'h1);
    repeat (2) @(negedge clk_sys_i);
    `CHK(irq_o, 1'b1)
    apb(1'b1, watchdog_pkg::ADR_IRQ_CL, 32'h0000_0008, 4'h1);
    repeat (2) @(negedge clk_sys_i);
    `CHK(irq_o, 1'b0)
    `CHK(wdt_reset_o, 1'b0)
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0061, 4'h1);
    wait_rst(10);
    apb(1'b0, watchdog_pkg::ADR_IRQ_ST, 32'h0000_0000, 4'h0);
    `CHK(rd[0], 1'b1)
    @(negedge clk_sys_i);
    `CHK(irq_o, 1'b1)
    // Source stopped: the second write leaves the reset pending
    do_reset(1'b0);
    src_run_i <= 1'b0;
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0061, 4'h1);
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0062, 4'h1);
    repeat (10) @(negedge clk_sys_i);
    `CHK(wdt_reset_o, 1'b0)
    apb(1'b0, watchdog_pkg::ADR_STATUS, 32'h0000_0000, 4'h0);
    `CHK(rd[2], 1'b1)
    src_run_i <= 1'b1;
    wait_rst(10);
    do_reset(1'b0);
    apb(1'b1, watchdog_pkg::ADR_KEY, {24'h00_0000, watchdog_pkg::KEY_CODE}, 4'h1);
    repeat (8) @(negedge clk_sys_i);
    `CHK(wdt_reset_o, 1'b0)
    apb(1'b1, watchdog_pkg::ADR_KEY, 32'h0000_0055, 4'h1);
    wait_rst(10);
    // Stop bit set, then a second write without it is swallowed: stays halted, no reset
    do_reset(1'b0);
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0071, 4'h1);
    rd_cnt(c_a);
    repeat (40) @(posedge clk_sys_i);
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0061, 4'h1);
    repeat (40) @(negedge clk_sys_i);
    rd_cnt(c_b);
    `CHK(c_b, c_a)
    @(negedge clk_sys_i);
    `CHK(wdt_reset_o, 1'b0)
    // Non-stoppable option: top bits forced, counting goes on in stop
    do_reset(1'b1);
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_00FF, 4'h1);
    apb(1'b0, watchdog_pkg::ADR_MODE, 32'h0000_0000, 4'h0);
    `CHK(rd[7:0], 8'h6F)
    stop_i <= 1'b1;
    rd_cnt(c_a);
    repeat (40) @(posedge clk_sys_i);
    rd_cnt(c_b);
    `CHK(c_b > c_a + 16'h0008, 1'b1)
    // Stoppable option: count held in halt, then resumes and overflows
    do_reset(1'b0);
    apb(1'b1, watchdog_pkg::ADR_IRQ_EN, 32'h0000_0004, 4'h1);
    apb(1'b1, watchdog_pkg::ADR_MODE, 32'h0000_0060, 4'h1);
    halt_i <= 1'b1;
    rd_cnt(c_a);
    repeat (40) @(posedge clk_sys_i);
    rd_cnt(c_b);
    `CHK(c_b, c_a)
    halt_i <= 1'b0;
    stop_i <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    rd_cnt(c_a);
    `CHK(c_a, c_b)
    stop_i <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    rd_cnt(c_a);
    `CHK(c_a > c_b + 16'h0008 && c_a < c_b + 16'h0010, 1'b1)
    wait_rst(1100);
    apb(1'b0, watchdog_pkg::ADR_IRQ_ST, 32'h0000_0000, 4'h0);
    `CHK(rd[2], 1'b1)
    @(negedge clk_sys_i);
    `CHK(irq_o, 1'b1)
    final_report();
  end
endmodule
`default_nettype wire
